// *** logic/plldet_regs.svh ***
// register offsets, field positions and timing counts of the lock detect block
`ifndef PLLDET_REGS_SVH
`define PLLDET_REGS_SVH
`define PLLDET_OFS_ABP_STAT 8'h17
`define PLLDET_OFS_LD_CFG 8'h18
`define PLLDET_OFS_DLY_CTL 8'h19
`define PLLDET_OFS_LDPIN 8'h1a
`define PLLDET_OFS_REFERENCE_MONITOR_PIN 8'h1b
`define PLLDET_OFS_HOLD_CMP 8'h1d
`define PLLDET_OFS_GATE_LO 8'hfc
`define PLLDET_OFS_GATE_HI 8'hfd
`define PLLDET_RST_ABP_STAT 8'h00
`define PLLDET_RST_LD_CFG 8'h00
`define PLLDET_RST_DLY_CTL 8'h00
`define PLLDET_RST_LDPIN 8'h00
`define PLLDET_RST_REFERENCE_MONITOR_PIN 8'h00
`define PLLDET_RST_HOLD_CMP 8'h00
`define PLLDET_RST_GATE 8'h00
`define PLLDET_BIT_WIN_RANGE 4
`define PLLDET_BIT_DLD_DIS 3
`define PLLDET_BIT_CMP_EN 3
`define PLLDET_BIT_RDLY_EN 2
`define PLLDET_BIT_NDLY_EN 5
`define PLLDET_SEL_DLD 6'h01
`define PLLDET_SEL_ALD_NOD 6'h02
`define PLLDET_SEL_ALD_POD 6'h03
`define PLLDET_SEL_CSRC 6'h04
`define PLLDET_SEL_CMP 6'h05
`define PLLDET_CNT_W 4
`define PLLDET_CNT_0 4'h5
`define PLLDET_CNT_1 4'h3
`define PLLDET_CNT_2 4'h7
`define PLLDET_CNT_3 4'hf
`define PLLDET_DLY_PS_PER_STEP 143
`endif

// *** logic/plldet_pkg.sv ***
// types shared by the lock detect block
package plldet_pkg;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
   } plldet_wr_t;
   typedef struct packed {
      logic lock_pin_o;
      logic lock_pin_oe;
      logic status_pin;
      logic reference_monitor_pin_pin;
   } plldet_pins_t;
   typedef enum logic [1:0] {PLLDET_HUNT, PLLDET_LOCKED} plldet_st_t;
endpackage

// *** logic/plldet_edge.sv ***
// synchroniser and rising edge detector for one phase detector input
module plldet_edge
(
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic sig,
   output logic rise
);
   logic s1_ff, s2_ff, s3_ff;
   // a rise counts while the second stage is high and the third still low
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         s1_ff <= 1'b0;
         s2_ff <= 1'b0;
         s3_ff <= 1'b0;
      end
      else
      begin
         s1_ff <= sig;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end
   assign rise = s2_ff & ~s3_ff;
endmodule

// *** logic/plldet_top.sv ***
// digital lock detector, lock pin drivers, output gating and delay decode
// Operation
// - r and n delay cells, 3-bit, up to 429 ps
// - lock after programmed count of in-window cycles
// - stay locked until one cycle exceeds unlock
// - windows depend on range and antibacklash
// - lock indication muxed onto three pins
// - analog lock pulses, pull-down or pull-up modes
// - current source while locked, ground otherwise
// - comparator output selectable on reference_monitor_pin, status
// - gate outputs on current source lock indication
// - fixed divide ignores a; b one bypasses
// - count code 00 means five cycles
// - detector runs only when disable bit clear
`include "plldet_regs.svh"
module plldet_top
(
   input wire logic ref_clk,
   input wire logic rstn,
   input wire plldet_pkg::plldet_wr_t reg_wr,
   input wire logic [7:0] reg_raddr,
   output logic [7:0] reg_rdata,
   input wire logic pfd_ref,
   input wire logic pfd_fb,
   input wire logic lock_pin_i,
   input wire logic [15:0] clk_out_en_req,
   input wire logic [1:0] prescaler_fd,
   input wire logic [12:0] b_count,
   input wire logic [5:0] a_count,
   output logic [15:0] clk_out_en,
   output logic [5:0] a_count_eff,
   output logic ab_bypass,
   output logic [3:0] r_delay,
   output logic [3:0] n_delay,
   output logic [9:0] r_delay_ps,
   output logic [9:0] n_delay_ps,
   output plldet_pkg::plldet_pins_t pins,
   output logic digital_lock_indication
);
   import plldet_pkg::*;
   // =========================================
   // registers
   logic [7:0] abp_ff, ldcfg_ff, dly_ff, ldpin_ff, reference_monitor_pin_ff, hold_ff, gate_lo_ff, gate_hi_ff;
   logic w_abp, w_ldcfg, w_dly, w_ldpin, w_reference_monitor_pin, w_hold, w_glo, w_ghi;
   assign w_abp = reg_wr.wr && reg_wr.addr == `PLLDET_OFS_ABP_STAT;
   assign w_ldcfg = reg_wr.wr && reg_wr.addr == `PLLDET_OFS_LD_CFG;
   assign w_dly = reg_wr.wr && reg_wr.addr == `PLLDET_OFS_DLY_CTL;
   assign w_ldpin = reg_wr.wr && reg_wr.addr == `PLLDET_OFS_LDPIN;
   assign w_reference_monitor_pin = reg_wr.wr && reg_wr.addr == `PLLDET_OFS_REFERENCE_MONITOR_PIN;
   assign w_hold = reg_wr.wr && reg_wr.addr == `PLLDET_OFS_HOLD_CMP;
   assign w_glo = reg_wr.wr && reg_wr.addr == `PLLDET_OFS_GATE_LO;
   assign w_ghi = reg_wr.wr && reg_wr.addr == `PLLDET_OFS_GATE_HI;
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         abp_ff <= `PLLDET_RST_ABP_STAT;
         ldcfg_ff <= `PLLDET_RST_LD_CFG;
         dly_ff <= `PLLDET_RST_DLY_CTL;
         ldpin_ff <= `PLLDET_RST_LDPIN;
         reference_monitor_pin_ff <= `PLLDET_RST_REFERENCE_MONITOR_PIN;
         hold_ff <= `PLLDET_RST_HOLD_CMP;
         gate_lo_ff <= `PLLDET_RST_GATE;
         gate_hi_ff <= `PLLDET_RST_GATE;
      end
      else
      begin
         if (w_abp) abp_ff <= reg_wr.wdata;
         if (w_ldcfg) ldcfg_ff <= reg_wr.wdata;
         if (w_dly) dly_ff <= reg_wr.wdata;
         if (w_ldpin) ldpin_ff <= {2'b00, reg_wr.wdata[5:0]};
         if (w_reference_monitor_pin) reference_monitor_pin_ff <= {3'b000, reg_wr.wdata[4:0]};
         if (w_hold) hold_ff <= reg_wr.wdata;
         if (w_glo) gate_lo_ff <= reg_wr.wdata;
         if (w_ghi) gate_hi_ff <= reg_wr.wdata;
      end
   end
   // reads: byte 0x18 bit 7 is unrelated here but kept, state shown in bit 2
   logic [7:0] nxt_rdata;
   logic [7:0] rdata_ff;
   always_comb
   begin
      unique case (reg_raddr)
         `PLLDET_OFS_ABP_STAT: nxt_rdata = abp_ff;
         `PLLDET_OFS_LD_CFG: nxt_rdata = {ldcfg_ff[7:3], digital_lock_indication, ldcfg_ff[1:0]};
         `PLLDET_OFS_DLY_CTL: nxt_rdata = dly_ff;
         `PLLDET_OFS_LDPIN: nxt_rdata = ldpin_ff;
         `PLLDET_OFS_REFERENCE_MONITOR_PIN: nxt_rdata = reference_monitor_pin_ff;
         `PLLDET_OFS_HOLD_CMP: nxt_rdata = hold_ff;
         `PLLDET_OFS_GATE_LO: nxt_rdata = gate_lo_ff;
         `PLLDET_OFS_GATE_HI: nxt_rdata = gate_hi_ff;
         default: nxt_rdata = 8'h00;
      endcase
   end
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn) rdata_ff <= 8'h00;
      else rdata_ff <= nxt_rdata;
   end
   assign reg_rdata = rdata_ff;
   // =========================================
   // divider delays and feedback bypass
   assign r_delay = {dly_ff[`PLLDET_BIT_RDLY_EN], 1'b0,
                     dly_ff[1:0] & {2{dly_ff[`PLLDET_BIT_RDLY_EN]}}};
   assign n_delay = {dly_ff[`PLLDET_BIT_NDLY_EN], 1'b0,
                     dly_ff[4:3] & {2{dly_ff[`PLLDET_BIT_NDLY_EN]}}};
   // 3-bit code: enable plus two step bits; three steps span 429 ps
   assign r_delay_ps = r_delay[3] ? 10'(r_delay[2:0] * `PLLDET_DLY_PS_PER_STEP) : 10'h000;
   assign n_delay_ps = n_delay[3] ? 10'(n_delay[2:0] * `PLLDET_DLY_PS_PER_STEP) : 10'h000;
   assign ab_bypass = (b_count == 13'h0001);
   assign a_count_eff = (prescaler_fd != 2'b00 || ab_bypass) ? 6'h00 : a_count;
   // =========================================
   // phase detector edges
   logic ref_rise, fb_rise;
   plldet_edge u_ref (.ref_clk(ref_clk), .rstn(rstn), .sig(pfd_ref), .rise(ref_rise));
   plldet_edge u_fb (.ref_clk(ref_clk), .rstn(rstn), .sig(pfd_fb), .rise(fb_rise));
   // window in ref_clk cycles; coarse because edges are sampled, limitation accepted
   logic [3:0] lock_win, unlock_win, need;
   assign lock_win = 4'(4'h1 + {2'b00, abp_ff[1:0]} + {3'b000, ldcfg_ff[`PLLDET_BIT_WIN_RANGE]});
   assign unlock_win = 4'(lock_win + 4'h2);
   always_comb
   begin
      unique case (ldcfg_ff[6:5])
         2'b00: need = `PLLDET_CNT_0;
         2'b01: need = `PLLDET_CNT_1;
         2'b10: need = `PLLDET_CNT_2;
         2'b11: need = `PLLDET_CNT_3;
      endcase
   end
   // measure ref-to-fb edge distance once per ref cycle
   logic [3:0] dist_ff, nxt_dist;
   logic armed_ff, nxt_armed, fb_seen_ff, nxt_fb_seen;
   logic [3:0] cnt_ff, nxt_cnt;
   plldet_st_t st_ff, nxt_st;
   logic dld_en, eval, in_lock_win, in_unlock_win;
   assign dld_en = ~ldcfg_ff[`PLLDET_BIT_DLD_DIS];
   assign eval = ref_rise & armed_ff;
   assign in_lock_win = fb_seen_ff && dist_ff < lock_win;
   assign in_unlock_win = fb_seen_ff && dist_ff <= unlock_win;
   always_comb
   begin
      nxt_armed = armed_ff | ref_rise;
      nxt_fb_seen = ref_rise ? fb_rise : (fb_seen_ff | fb_rise);
      nxt_dist = dist_ff;
      if (ref_rise) nxt_dist = 4'h0;
      else if (!fb_seen_ff && dist_ff != 4'hf) nxt_dist = 4'(dist_ff + 4'h1);
      nxt_cnt = cnt_ff;
      nxt_st = st_ff;
      if (!dld_en)
      begin
         nxt_cnt = 4'h0;
         nxt_st = PLLDET_HUNT;
      end
      else if (eval)
      begin
         unique case (st_ff)
            PLLDET_HUNT:
            begin
               if (!in_lock_win) nxt_cnt = 4'h0;
               else if (4'(cnt_ff + 4'h1) >= need) nxt_st = PLLDET_LOCKED;
               else nxt_cnt = 4'(cnt_ff + 4'h1);
            end
            PLLDET_LOCKED:
            begin
               if (!in_unlock_win)
               begin
                  nxt_st = PLLDET_HUNT;
                  nxt_cnt = 4'h0;
               end
            end
         endcase
      end
   end
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         dist_ff <= 4'h0;
         armed_ff <= 1'b0;
         fb_seen_ff <= 1'b0;
         cnt_ff <= 4'h0;
         st_ff <= PLLDET_HUNT;
      end
      else
      begin
         dist_ff <= nxt_dist;
         armed_ff <= nxt_armed;
         fb_seen_ff <= nxt_fb_seen;
         cnt_ff <= nxt_cnt;
         st_ff <= nxt_st;
      end
   end
   assign digital_lock_indication = (st_ff == PLLDET_LOCKED);
   // =========================================
   // lock pin, status and reference_monitor_pin muxes
   logic [5:0] ld_sel;
   logic ald_pulse, analog_lock_indication, current_source_lock_indication, cmp_out;
   assign ld_sel = ldpin_ff[5:0];
   // phase error pulse while only one edge seen in the current cycle
   assign ald_pulse = armed_ff & ~fb_seen_ff & (dist_ff != 4'h0);
   assign analog_lock_indication = ~ald_pulse;
   assign cmp_out = hold_ff[`PLLDET_BIT_CMP_EN] ? lock_pin_i : 1'b1;
   assign current_source_lock_indication = (ld_sel == `PLLDET_SEL_CSRC) & cmp_out;
   logic ld_o, ld_oe;
   always_comb
   begin
      ld_o = 1'b0;
      ld_oe = 1'b0;
      unique case (ld_sel)
         `PLLDET_SEL_DLD:
         begin
            ld_o = digital_lock_indication;
            ld_oe = 1'b1;
         end
         `PLLDET_SEL_ALD_NOD:
         begin
            ld_oe = ald_pulse;
         end
         `PLLDET_SEL_ALD_POD:
         begin
            ld_o = 1'b1;
            ld_oe = ald_pulse;
         end
         `PLLDET_SEL_CSRC:
         begin
            // high drive models the current source; low shorts the capacitor
            ld_o = digital_lock_indication;
            ld_oe = 1'b1;
         end
         default:
         begin
            ld_o = 1'b0;
            ld_oe = 1'b0;
         end
      endcase
   end
   logic [5:0] stat_sel;
   logic [4:0] rmon_sel;
   assign stat_sel = abp_ff[7:2];
   assign rmon_sel = reference_monitor_pin_ff[4:0];
   assign pins.lock_pin_o = ld_o;
   assign pins.lock_pin_oe = ld_oe;
   assign pins.status_pin = (stat_sel == `PLLDET_SEL_DLD) ? digital_lock_indication :
                            (stat_sel == `PLLDET_SEL_CMP) ? cmp_out : 1'b0;
   assign pins.reference_monitor_pin_pin = (rmon_sel == 5'(`PLLDET_SEL_DLD)) ? digital_lock_indication :
                            (rmon_sel == 5'(`PLLDET_SEL_CMP)) ? cmp_out : 1'b0;
   // =========================================
   // output gating, combinational so enables follow asynchronously
   logic [15:0] gate;
   assign gate = {gate_hi_ff, gate_lo_ff};
   genvar gi;
   generate
      for (gi = 0; gi < 16; gi = gi + 1)
      begin : g_gate
         assign clk_out_en[gi] = clk_out_en_req[gi] & (~gate[gi] | current_source_lock_indication);
      end
   endgenerate
   // =========================================
   // checks
   lock_needs_cycles_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      $rose(digital_lock_indication) |-> $past(eval) && $past(in_lock_win))
      else $error("lock without in-window cycle");
   unlock_single_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      digital_lock_indication && eval && !in_unlock_win && dld_en |=> !digital_lock_indication)
      else $error("lock held past unlock cycle");
   hold_lock_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      digital_lock_indication && !(eval && !in_unlock_win) && dld_en |=> digital_lock_indication)
      else $error("lock dropped without cause");
   dld_disable_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      !dld_en |=> !digital_lock_indication)
      else $error("lock while disabled");
   miss_clear_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      st_ff == PLLDET_HUNT && eval && !in_lock_win |=> cnt_ff == 4'h0)
      else $error("count not cleared");
   gate_out_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      gate[0] && !current_source_lock_indication |-> !clk_out_en[0])
      else $error("gated output enabled");
   csrc_pin_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      ld_sel == `PLLDET_SEL_CSRC |-> ld_oe && ld_o == digital_lock_indication)
      else $error("current source pin wrong");
   bypass_a_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      prescaler_fd != 2'b00 |-> a_count_eff == 6'h00)
      else $error("a counter used in fixed divide");
   five_cycle_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      ldcfg_ff[6:5] == 2'b00 && st_ff == PLLDET_HUNT && cnt_ff < 4'h4 |=> st_ff == PLLDET_HUNT)
      else $error("locked before five cycles");
endmodule

// *** testbench/plldet_cap_model.sv ***
// behavioural lock pin capacitor with its comparator trip level
module plldet_cap_model
#(
   parameter int CHARGE = 40
)
(
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic lock_pin_o,
   input wire logic lock_pin_oe,
   output logic lock_pin_i
);
   timeunit 1ns;
   timeprecision 1ps;
   int level = 0;
   // ==========================================================
   // charge store
   // capacitor to ground fitted on the lock pin
   always @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         level <= 0;
      else if (lock_pin_oe && !lock_pin_o)
         level <= 0; // short to ground dumps the charge at once
      else if (lock_pin_oe)
         level <= (level < 2 * CHARGE) ? level + 1 : level;
      else if (level > 0)
         level <= level - 1; // undriven pin leaks, never holds forever
   end
   assign lock_pin_i = (level >= CHARGE);
endmodule

// *** testbench/pll_lock_detect_and_divider_delay_tb.sv ***
// self-checking bench for the lock detector, lock pin modes and divider decode
`include "plldet_regs.svh"
module pll_lock_detect_and_divider_delay_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import plldet_pkg::*;
   localparam int PFD_HALF = 8; // 16-clock pfd period exceeds every unlock window
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   plldet_wr_t reg_wr = '0;
   logic [7:0] reg_raddr = 8'h00;
   logic [7:0] reg_rdata;
   logic pfd_ref = 1'b0;
   logic pfd_fb = 1'b0;
   logic lock_pin_i;
   logic [15:0] clk_out_en_req = 16'h0000;
   logic [1:0] prescaler_fd = 2'h0;
   logic [12:0] b_count = 13'h0005;
   logic [5:0] a_count = 6'h03;
   logic [15:0] clk_out_en;
   logic [5:0] a_count_eff;
   logic ab_bypass;
   logic [3:0] r_delay, n_delay;
   logic [9:0] r_delay_ps, n_delay_ps;
   plldet_pins_t pins;
   logic lock;
   int errors = 0;
   int check_count = 0;
   int cycles = 0;
   int oe_cnt = 0;
   int o_cnt = 0;
   int ald0;
   int oe0;
   int o0;
   logic [3:0] need [4] = '{4'h5, 4'h3, 4'h7, 4'hf};
   logic [7:0] ofs [9] = '{`PLLDET_OFS_ABP_STAT, `PLLDET_OFS_LD_CFG, `PLLDET_OFS_DLY_CTL,
      `PLLDET_OFS_LDPIN, `PLLDET_OFS_REFERENCE_MONITOR_PIN, `PLLDET_OFS_HOLD_CMP, `PLLDET_OFS_GATE_LO,
      `PLLDET_OFS_GATE_HI, 8'h20};

   plldet_top dut (.ref_clk(ref_clk), .rstn(rstn), .reg_wr(reg_wr), .reg_raddr(reg_raddr),
      .reg_rdata(reg_rdata), .pfd_ref(pfd_ref), .pfd_fb(pfd_fb), .lock_pin_i(lock_pin_i),
      .clk_out_en_req(clk_out_en_req), .prescaler_fd(prescaler_fd), .b_count(b_count),
      .a_count(a_count), .clk_out_en(clk_out_en), .a_count_eff(a_count_eff),
      .ab_bypass(ab_bypass), .r_delay(r_delay), .n_delay(n_delay), .r_delay_ps(r_delay_ps),
      .n_delay_ps(n_delay_ps), .pins(pins), .digital_lock_indication(lock));
   plldet_cap_model #(.CHARGE(40)) cap (.ref_clk(ref_clk), .rstn(rstn),
      .lock_pin_o(pins.lock_pin_o), .lock_pin_oe(pins.lock_pin_oe), .lock_pin_i(lock_pin_i));

   always #20 ref_clk = ~ref_clk;

   // ==========================================================
   // tasks
   task automatic final_report();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp)
      begin
         errors++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_wr = '{addr: a, wdata: d, wr: 1'b1};
      @(negedge ref_clk);
      reg_wr.wr = 1'b0;
      @(negedge ref_clk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      reg_raddr = a;
      @(negedge ref_clk);
      chk("rdata", 16'(exp), 16'(reg_rdata));
   endtask

   // whole pfd cycles, feedback rising off clocks after reference
   // feedback drops a clock before the cycle ends so a late pulse never merges
   // with an aligned one that follows
   task automatic pfd(input int n, input int off);
      repeat (n)
      for (int k = 0; k < 2 * PFD_HALF; k++)
      begin
         pfd_ref = (k < PFD_HALF);
         pfd_fb = (k >= off) && (k < off + PFD_HALF - 1);
         @(negedge ref_clk);
      end
   endtask

   // ==========================================================
   // watchdog and lock pin pulse counters
   always @(posedge ref_clk)
   begin
      cycles <= cycles + 1;
      oe_cnt <= oe_cnt + int'(pins.lock_pin_oe);
      o_cnt <= o_cnt + int'(pins.lock_pin_oe & pins.lock_pin_o);
      if (cycles == 20000)
      begin
         errors++;
         final_report();
      end
   end

   // ==========================================================
   // main sequence
   initial
   begin
      repeat (3) @(negedge ref_clk);
      rstn = 1'b1;
      @(negedge ref_clk);
      foreach (ofs[i]) rd(ofs[i], 8'h00);
      wr(`PLLDET_OFS_LDPIN, 8'hff);
      rd(`PLLDET_OFS_LDPIN, 8'h3f);
      wr(`PLLDET_OFS_REFERENCE_MONITOR_PIN, 8'hff);
      rd(`PLLDET_OFS_REFERENCE_MONITOR_PIN, 8'h1f);
      wr(8'h20, 8'hff);
      rd(8'h20, 8'h00);
      wr(`PLLDET_OFS_GATE_LO, 8'ha5);
      rd(`PLLDET_OFS_GATE_LO, 8'ha5);
      wr(`PLLDET_OFS_LDPIN, 8'h00);
      wr(`PLLDET_OFS_REFERENCE_MONITOR_PIN, 8'h00);
      wr(`PLLDET_OFS_GATE_LO, 8'h00);
      wr(`PLLDET_OFS_DLY_CTL, 8'h3f);
      chk("r_delay", 16'h000b, 16'(r_delay));
      chk("n_delay_ps", 16'd429, 16'(n_delay_ps));
      chk("r_delay_ps", 16'd429, 16'(r_delay_ps));
      wr(`PLLDET_OFS_DLY_CTL, 8'h2a);
      chk("r_delay", 16'h0000, 16'(r_delay));
      chk("n_delay", 16'h0009, 16'(n_delay));
      chk("n_delay_ps", 16'd143, 16'(n_delay_ps));
      chk("r_delay_ps", 16'd0, 16'(r_delay_ps));
      chk("a_eff", 16'h0003, 16'(a_count_eff));
      prescaler_fd = 2'h1; // divide-by-one setting, no 2/3 use
      #1 chk("a_eff", 16'h0000, 16'(a_count_eff));
      prescaler_fd = 2'h0;
      b_count = 13'h0001;
      #1 chk("bypass", 16'h0001, 16'(ab_bypass));
      chk("a_eff", 16'h0000, 16'(a_count_eff));
      // every count code: one miss, then need-1 hits stay unlocked
      for (int c = 0; c < 4; c++)
      begin
         wr(`PLLDET_OFS_LD_CFG, 8'(c << 5));
         pfd(1, 8);
         pfd(int'(need[c]), 0);
         chk("lock_early", 16'h0000, 16'(lock));
         pfd(1, 0);
         chk("lock", 16'h0001, 16'(lock));
      end
      wr(`PLLDET_OFS_LD_CFG, 8'h20);
      pfd(3, 2);
      chk("lock_hyst", 16'h0001, 16'(lock));
      pfd(1, 4);
      pfd(1, 0);
      chk("unlock", 16'h0000, 16'(lock));
      pfd(4, 2);
      chk("lock_abp0", 16'h0000, 16'(lock));
      wr(`PLLDET_OFS_ABP_STAT, 8'h02);
      pfd(4, 2);
      chk("lock_abp2", 16'h0001, 16'(lock));
      wr(`PLLDET_OFS_ABP_STAT, 8'h00);
      wr(`PLLDET_OFS_LD_CFG, 8'h30);
      pfd(1, 8);
      pfd(4, 1);
      pfd(2, 3);
      chk("lock_range", 16'h0001, 16'(lock));
      rd(`PLLDET_OFS_LD_CFG, 8'h34);
      wr(`PLLDET_OFS_LD_CFG, 8'h38);
      pfd(4, 0);
      chk("lock_dis", 16'h0000, 16'(lock));
      wr(`PLLDET_OFS_LD_CFG, 8'h20);
      pfd(1, 8);
      pfd(4, 0);
      // current source mode gating outputs
      wr(`PLLDET_OFS_GATE_LO, 8'hff);
      wr(`PLLDET_OFS_GATE_HI, 8'h01);
      clk_out_en_req = 16'hffff;
      wr(`PLLDET_OFS_HOLD_CMP, 8'h08);
      wr(`PLLDET_OFS_ABP_STAT, 8'h14);
      wr(`PLLDET_OFS_REFERENCE_MONITOR_PIN, 8'h05);
      wr(`PLLDET_OFS_LDPIN, 8'h04);
      chk("pin_src", 16'h0003, 16'({pins.lock_pin_oe, pins.lock_pin_o}));
      chk("status", 16'h0000, 16'(pins.status_pin));
      chk("gate", 16'hfe00, clk_out_en);
      pfd(4, 0);
      chk("status", 16'h0001, 16'(pins.status_pin));
      chk("reference_monitor_pin", 16'h0001, 16'(pins.reference_monitor_pin_pin));
      chk("gate", 16'hffff, clk_out_en);
      pfd(2, 8);
      chk("pin_gnd", 16'h0002, 16'({pins.lock_pin_oe, pins.lock_pin_o}));
      chk("gate", 16'hfe00, clk_out_en);
      wr(`PLLDET_OFS_HOLD_CMP, 8'h00);
      chk("status_cmp_off", 16'h0001, 16'(pins.status_pin));
      // plain lock indication on all three pins
      pfd(4, 0);
      wr(`PLLDET_OFS_LDPIN, 8'h01);
      wr(`PLLDET_OFS_ABP_STAT, 8'h04);
      wr(`PLLDET_OFS_REFERENCE_MONITOR_PIN, 8'h01);
      chk("mux_on", 16'h0007, 16'({pins.lock_pin_o, pins.status_pin, pins.reference_monitor_pin_pin}));
      pfd(2, 8);
      chk("mux_off", 16'h0000, 16'({pins.lock_pin_o, pins.status_pin, pins.reference_monitor_pin_pin}));
      // analog pulse modes: wider phase error gives wider pulses
      wr(`PLLDET_OFS_LDPIN, 8'h02);
      oe0 = oe_cnt;
      pfd(4, 0);
      ald0 = oe_cnt - oe0;
      chk("ald_aligned", 16'h0000, 16'(ald0));
      oe0 = oe_cnt;
      o0 = o_cnt;
      pfd(4, 4);
      chk("ald_n_level", 16'h0000, 16'(o_cnt - o0));
      chk("ald_width", 16'h0001, 16'((oe_cnt - oe0) > ald0));
      wr(`PLLDET_OFS_LDPIN, 8'h03);
      oe0 = oe_cnt;
      o0 = o_cnt;
      pfd(4, 4);
      chk("ald_p_level", 16'h0001, 16'((o_cnt - o0) == (oe_cnt - oe0) && oe_cnt > oe0));
      final_report();
   end
endmodule
